//--- hdl/cc_event_unit.sv
`timescale 1ns/1ps
module cc_event_unit
   import timer_ch345_pkg::*;
#(
   parameter int CC_N = 4,
   parameter int W = 16
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] count,
   input wire logic [CC_N*W-1:0] cc_value,
   input wire logic [CC_N-1:0] capture_mode,
   input wire logic [CC_N-1:0] capture_strobe,
   output logic wrap_evt,
   output logic [CC_N-1:0] cc_evt
);

   typedef struct packed {
      logic [W-1:0] cnt_prev;
      logic [CC_N-1:0] match_prev;
      logic wrap_evt;
      logic [CC_N-1:0] cc_evt;
   } evt_state_s;

   evt_state_s state_reg;
   evt_state_s state_next;
   logic [CC_N-1:0] match;
   logic [CC_N-1:0] hit;

   ////////////////////////////////////////////////////////////////////////////
   genvar i;
   generate
      for (i = 0; i < CC_N; i++)
      begin : g_cc
         // Compare only in compare mode
         assign match[i] = ~capture_mode[i] && (count == cc_value[i*W +: W]);
         // Edge of the match, so a held equality sets the flag once
         assign hit[i] = (capture_mode[i] & capture_strobe[i])
            | (match[i] & ~state_reg.match_prev[i]);
      end
   endgenerate

   always_comb
   begin
      state_next = state_reg;
      state_next.cnt_prev = count;
      state_next.match_prev = match;
      state_next.wrap_evt = (state_reg.cnt_prev == {W{1'b1}}) && (count == {W{1'b0}});
      state_next.cc_evt = hit;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end

   assign wrap_evt = state_reg.wrap_evt;
   assign cc_evt = state_reg.cc_evt;

endmodule

//--- hdl/timer_ch345_irq_flags.sv
// What this block does
// - Enable bit 7 gates the channel 4 overflow request.
// - Enable bit 6 gates the channel 4 compare D request.
// - Enable bit 5 gates the channel 4 compare C request.
// - Enable bit 4 gates the channel 4 compare B request.
// - Enable bit 3 gates the channel 4 compare A request.
// - Enable bit 2 gates the channel 5 overflow request.
// - Enable bit 1 gates the channel 5 compare B request.
// - Enable bit 0 gates the channel 5 compare A request.
// - All enable bits read zero after reset.
// - Writing zero clears a flag and writing one does nothing.
// - A zero clears a flag only after that flag was read as one.
// - The overflow flag sets when the counter wraps from all ones to zero.
// - In capture mode the flag sets when a capture strobe loads the register.
// - In compare mode the flag sets when counter and register become equal.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module timer_ch345_irq_flags
   import timer_ch345_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [CNT_W-1:0] ch4_counter,
   input wire logic [CH4_CC_N*CNT_W-1:0] ch4_cc_value,
   input wire logic [CH4_CC_N-1:0] ch4_capture_strobe,
   input wire logic [CNT_W-1:0] ch5_counter,
   input wire logic [CH5_CC_N*CNT_W-1:0] ch5_cc_value,
   input wire logic [CH5_CC_N-1:0] ch5_capture_strobe,
   output logic ch4_wrap_irq,
   output logic ch4_cc_d_irq,
   output logic ch4_cc_c_irq,
   output logic ch4_cc_b_irq,
   output logic ch4_cc_a_irq,
   output logic ch5_wrap_irq,
   output logic ch5_cc_b_irq,
   output logic ch5_cc_a_irq,
   output logic irq
);

   typedef struct packed {
      logic [REG_W-1:0] enable;
      logic [MODE_W-1:0] mode;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [REG_W-1:0] req;
      logic irq;
   } top_state_s;

   top_state_s state_reg;
   top_state_s state_next;

   logic setup;
   logic done;
   logic hit_en;
   logic hit_st;
   logic hit_md;
   logic rd_done;
   logic wr_st_done;
   logic ch4_wrap_evt;
   logic [CH4_CC_N-1:0] ch4_cc_evt;
   logic ch5_wrap_evt;
   logic [CH5_CC_N-1:0] ch5_cc_evt;
   logic [REG_W-1:0] set_evt;
   logic [REG_W-1:0] flags;

   ////////////////////////////////////////////////////////////////////////////
   // Event sources, one unit per channel
   cc_event_unit #(
      .CC_N(CH4_CC_N),
      .W(CNT_W)
   ) u_ch4_events (
      .pclk(pclk),
      .presetn(presetn),
      .count(ch4_counter),
      .cc_value(ch4_cc_value),
      .capture_mode(state_reg.mode[MODE_CH4_LSB +: CH4_CC_N]),
      .capture_strobe(ch4_capture_strobe),
      .wrap_evt(ch4_wrap_evt),
      .cc_evt(ch4_cc_evt)
   );

   cc_event_unit #(
      .CC_N(CH5_CC_N),
      .W(CNT_W)
   ) u_ch5_events (
      .pclk(pclk),
      .presetn(presetn),
      .count(ch5_counter),
      .cc_value(ch5_cc_value),
      .capture_mode(state_reg.mode[MODE_CH5_LSB +: CH5_CC_N]),
      .capture_strobe(ch5_capture_strobe),
      .wrap_evt(ch5_wrap_evt),
      .cc_evt(ch5_cc_evt)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Status layout: overflow on top, compare A lowest
   always_comb
   begin
      set_evt = '0;
      set_evt[CH4_WRAP_BIT] = ch4_wrap_evt;
      set_evt[CH4_CC_D_BIT] = ch4_cc_evt[3];
      set_evt[CH4_CC_C_BIT] = ch4_cc_evt[2];
      set_evt[CH4_CC_B_BIT] = ch4_cc_evt[1];
      set_evt[CH4_CC_A_BIT] = ch4_cc_evt[0];
      set_evt[CH5_WRAP_BIT] = ch5_wrap_evt;
      set_evt[CH5_CC_B_BIT] = ch5_cc_evt[1];
      set_evt[CH5_CC_A_BIT] = ch5_cc_evt[0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB decode; address is held through the access phase
   assign setup = psel & ~penable;
   assign done = psel & penable & state_reg.pready;
   assign hit_en = (paddr[31:2] == ENABLE_LOW_IDX[29:0]);
   assign hit_st = (paddr[31:2] == STATUS_LOW_IDX[29:0]);
   assign hit_md = (paddr[31:2] == CC_MODE_IDX[29:0]);
   assign rd_done = done & ~pwrite & hit_st;
   assign wr_st_done = done & pwrite & hit_st;

   // Arms only bits the master actually saw as one
   wc_flag_bank #(
      .W(REG_W)
   ) u_flags (
      .pclk(pclk),
      .presetn(presetn),
      .set_evt(set_evt),
      .rd_done(rd_done),
      .rd_bits(state_reg.prdata[REG_W-1:0]),
      .wr_done(wr_st_done),
      .wr_bits(pwdata[REG_W-1:0]),
      .flags(flags)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      state_next = state_reg;

      // One wait-free access: ready rises in the access phase
      state_next.pready = setup;
      state_next.pslverr = setup & ~(hit_en | hit_st | hit_md);

      // Read data snapshot at setup so it is stable when sampled
      if (setup & ~pwrite)
      begin
         state_next.prdata = '0;
         if (hit_en)
            state_next.prdata[REG_W-1:0] = state_reg.enable;
         else if (hit_st)
            state_next.prdata[REG_W-1:0] = flags;
         else if (hit_md)
            state_next.prdata[MODE_W-1:0] = state_reg.mode;
      end

      if (done & pwrite & hit_en)
         state_next.enable = pwdata[REG_W-1:0];
      if (done & pwrite & hit_md)
         state_next.mode = pwdata[MODE_W-1:0];

      // Requests follow flag and enable, one cycle later
      state_next.req = flags & state_reg.enable;
      state_next.irq = |(flags & state_reg.enable);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= '0;
         state_reg.enable <= ENABLE_RESET;
         state_reg.mode <= MODE_RESET;
      end
      else
         state_reg <= state_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   assign prdata = state_reg.prdata;
   assign pready = state_reg.pready;
   assign pslverr = state_reg.pslverr;
   assign ch4_wrap_irq = state_reg.req[CH4_WRAP_BIT];
   assign ch4_cc_d_irq = state_reg.req[CH4_CC_D_BIT];
   assign ch4_cc_c_irq = state_reg.req[CH4_CC_C_BIT];
   assign ch4_cc_b_irq = state_reg.req[CH4_CC_B_BIT];
   assign ch4_cc_a_irq = state_reg.req[CH4_CC_A_BIT];
   assign ch5_wrap_irq = state_reg.req[CH5_WRAP_BIT];
   assign ch5_cc_b_irq = state_reg.req[CH5_CC_B_BIT];
   assign ch5_cc_a_irq = state_reg.req[CH5_CC_A_BIT];
   assign irq = state_reg.irq;

endmodule

//--- hdl/wc_flag_bank.sv
`timescale 1ns/1ps
module wc_flag_bank
   import timer_ch345_pkg::*;
#(
   parameter int W = 8
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] set_evt,
   input wire logic rd_done,
   input wire logic [W-1:0] rd_bits,
   input wire logic wr_done,
   input wire logic [W-1:0] wr_bits,
   output logic [W-1:0] flags
);

   typedef struct packed {
      logic [W-1:0] flags;
      logic [W-1:0] armed;
   } flag_state_s;

   flag_state_s state_reg;
   flag_state_s state_next;
   logic [W-1:0] clr;

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      state_next = state_reg;
      clr = '0;
      // A zero clears only a bit that was last read as one
      if (wr_done)
         clr = state_reg.armed & ~wr_bits;
      // Any status write uses up the earlier read
      if (wr_done)
         state_next.armed = '0;
      else if (rd_done)
         state_next.armed = state_reg.armed | rd_bits;
      // Set wins so a coincident event is never lost
      state_next.flags = (state_reg.flags & ~clr) | set_evt;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end

   assign flags = state_reg.flags;

endmodule

//--- include/timer_ch345_pkg.sv
package timer_ch345_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register indices; byte address is four times the index
   localparam logic [31:0] ENABLE_LOW_IDX = 32'hffff8204;
   localparam logic [31:0] STATUS_LOW_IDX = 32'hffff8205;
   localparam logic [31:0] CC_MODE_IDX = 32'hffff8280;

   ////////////////////////////////////////////////////////////////////////////
   // Widths and reset values
   localparam int REG_W = 8;
   localparam int CNT_W = 16;
   localparam int CH4_CC_N = 4;
   localparam int CH5_CC_N = 2;
   localparam int MODE_W = 6;
   localparam logic [REG_W-1:0] ENABLE_RESET = 8'h00;
   localparam logic [REG_W-1:0] STATUS_RESET = 8'h00;
   localparam logic [MODE_W-1:0] MODE_RESET = 6'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Bit positions shared by enable and status registers
   localparam int CH4_WRAP_BIT = 7;
   localparam int CH4_CC_D_BIT = 6;
   localparam int CH4_CC_C_BIT = 5;
   localparam int CH4_CC_B_BIT = 4;
   localparam int CH4_CC_A_BIT = 3;
   localparam int CH5_WRAP_BIT = 2;
   localparam int CH5_CC_B_BIT = 1;
   localparam int CH5_CC_A_BIT = 0;

   // Mode register: 1 = input capture, 0 = output compare
   localparam int MODE_CH4_LSB = 0;
   localparam int MODE_CH5_LSB = 4;

endpackage

//--- verification/timer_ch345_irq_flags_asserts.sv
`timescale 1ns/1ps
module timer_ch345_irq_flags_asserts
   import timer_ch345_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic ch4_wrap_irq,
   input wire logic ch4_cc_d_irq,
   input wire logic ch4_cc_c_irq,
   input wire logic ch4_cc_b_irq,
   input wire logic ch4_cc_a_irq,
   input wire logic ch5_wrap_irq,
   input wire logic ch5_cc_b_irq,
   input wire logic ch5_cc_a_irq,
   input wire logic irq
);
   logic [7:0] req;
   logic mapped;
   logic en_seen;
   assign req = {ch4_wrap_irq, ch4_cc_d_irq, ch4_cc_c_irq, ch4_cc_b_irq,
                 ch4_cc_a_irq, ch5_wrap_irq, ch5_cc_b_irq, ch5_cc_a_irq};
   assign mapped = paddr[31:2] == ENABLE_LOW_IDX[29:0] || paddr[31:2] == STATUS_LOW_IDX[29:0]
                   || paddr[31:2] == CC_MODE_IDX[29:0];
   // No request can exist before software ever writes the enable register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         en_seen <= 1'b0;
      else if (psel && penable && pwrite && paddr[31:2] == ENABLE_LOW_IDX[29:0])
         en_seen <= 1'b1;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////////
   setup_ack_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
   ready_once_a: assert property (pready |=> !pready) else $error("ready held too long");
   err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
   unmapped_err_a: assert property (psel && !penable && !mapped |=> pslverr) else $error("no error");
   mapped_ok_a: assert property (psel && !penable && mapped |=> !pslverr) else $error("bad error");
   upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits");
   refused_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("refused data");
   irq_or_a: assert property (irq == (|req)) else $error("irq not or of requests");
   reset_mask_a: assert property (!en_seen |-> req == 8'h0) else $error("request while masked");
endmodule
bind timer_ch345_irq_flags timer_ch345_irq_flags_asserts u_chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .prdata, .pready, .pslverr, .ch4_wrap_irq, .ch4_cc_d_irq, .ch4_cc_c_irq,
   .ch4_cc_b_irq, .ch4_cc_a_irq, .ch5_wrap_irq, .ch5_cc_b_irq, .ch5_cc_a_irq, .irq);

//--- verification/timer_ch345_irq_flags_tb_top.sv
`timescale 1ns/1ps
module timer_ch345_irq_flags_tb_top
   import timer_ch345_pkg::*;
;
   localparam logic [31:0] EN_A = {ENABLE_LOW_IDX[29:0], 2'b00};
   localparam logic [31:0] ST_A = {STATUS_LOW_IDX[29:0], 2'b00};
   localparam logic [31:0] MD_A = {CC_MODE_IDX[29:0], 2'b00};
   localparam logic [31:0] BAD_A = 32'h00000100;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [31:0] paddr, pwdata, prdata, r;
   logic e;
   logic [15:0] ch4_counter, ch5_counter;
   logic [63:0] ch4_cc_value;
   logic [31:0] ch5_cc_value;
   logic [3:0] ch4_capture_strobe;
   logic [1:0] ch5_capture_strobe;
   logic ch4_wrap_irq, ch4_cc_d_irq, ch4_cc_c_irq, ch4_cc_b_irq, ch4_cc_a_irq;
   logic ch5_wrap_irq, ch5_cc_b_irq, ch5_cc_a_irq;
   logic [7:0] req;
   int num_errors = 0;
   int checks = 0;
   assign req = {ch4_wrap_irq, ch4_cc_d_irq, ch4_cc_c_irq, ch4_cc_b_irq,
                 ch4_cc_a_irq, ch5_wrap_irq, ch5_cc_b_irq, ch5_cc_a_irq};

   timer_ch345_irq_flags u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .ch4_counter, .ch4_cc_value, .ch4_capture_strobe, .ch5_counter,
      .ch5_cc_value, .ch5_capture_strobe, .ch4_wrap_irq, .ch4_cc_d_irq, .ch4_cc_c_irq,
      .ch4_cc_b_irq, .ch4_cc_a_irq, .ch5_wrap_irq, .ch5_cc_b_irq, .ch5_cc_a_irq, .irq);

   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Entered just after a rising edge; returns one edge after release
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
      begin
         num_errors++;
         give_verdict();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(r, exp);
   endtask
   // Bit number of the status layout selects the event source
   task automatic ev(input int b);
      if (b == 7)
         ch4_counter <= 16'hffff;
      else if (b == 2)
         ch5_counter <= 16'hffff;
      else if (b > 2)
         ch4_capture_strobe <= 4'(1 << (b - 3));
      else
         ch5_capture_strobe <= 2'(1 << b);
      @(posedge pclk);
      ch4_counter <= 16'h0;
      ch5_counter <= 16'h0;
      ch4_capture_strobe <= 4'h0;
      ch5_capture_strobe <= 2'h0;
      repeat (5) @(posedge pclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      // Nonzero compare values keep a counter at zero from matching
      ch4_counter = 16'h0100;
      ch5_counter = 16'h0100;
      ch4_cc_value = {4{16'h1234}};
      ch5_cc_value = {2{16'h1234}};
      ch4_capture_strobe = 4'h0;
      ch5_capture_strobe = 2'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(EN_A, 32'h0);
      rd(ST_A, 32'h0);
      apb(1'b1, BAD_A, 32'hff);
      chk(e, 1'b1);
      rd(BAD_A, 32'h0);
      chk(e, 1'b1);
      apb(1'b1, EN_A, 32'h5a);
      rd(EN_A, 32'h5a);
      apb(1'b1, MD_A, 32'h3f);
      rd(MD_A, 32'h3f);
      for (int b = 0; b < 8; b++)
      begin
         apb(1'b1, EN_A, ~(32'h1 << b) & 32'hff);
         ev(b);
         chk(req, 32'h0);
         rd(ST_A, 32'h1 << b);
         apb(1'b1, EN_A, 32'hff);
         repeat (2) @(posedge pclk);
         chk(req, 32'h1 << b);
         apb(1'b1, ST_A, 32'hff);
         apb(1'b1, ST_A, 32'h0);
         rd(ST_A, 32'h1 << b);
         apb(1'b1, ST_A, 32'h0);
         rd(ST_A, 32'h0);
         chk(req, 32'h0);
      end
      apb(1'b1, MD_A, 32'h0);
      ch4_counter <= 16'h1234;
      ch5_counter <= 16'h1234;
      repeat (5) @(posedge pclk);
      rd(ST_A, 32'h7b);
      chk(req, 32'h7b);
      apb(1'b1, ST_A, 32'h0);
      rd(ST_A, 32'h0);
      // Back to capture, else the strobe below is ignored
      apb(1'b1, MD_A, 32'h3f);
      ev(0);
      chk(irq, 1'b1);
      apb(1'b1, EN_A, 32'h0);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      give_verdict();
   end
endmodule
